/* File: design/fct_serializer.sv */
`default_nettype none
module fct_serializer
  import fct_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        bit_en,
  input  wire logic        load,
  input  wire logic [15:0] word,
  output logic             tx_bit,
  output logic             word_done
);

  typedef struct packed {
    logic [15:0] shift;
    logic [3:0]  cnt;
    logic        active;
    logic        bit_out;
    logic        done;
  } fct_ser_t;

  fct_ser_t s_ff;
  fct_ser_t nxt_s;

  always_comb begin
    nxt_s      = s_ff;
    nxt_s.done = 1'b0;
    if (bit_en) begin
      nxt_s.bit_out = s_ff.shift[0];
      nxt_s.shift   = {1'b1, s_ff.shift[15:1]};
      if (s_ff.active) begin
        nxt_s.cnt = s_ff.cnt + 4'h1;
        if (s_ff.cnt == WORD_LAST) begin
          nxt_s.active = 1'b0;
          nxt_s.done   = 1'b1;
        end
      end
    end
    // a load restarts the word at once, dropping any word in flight
    if (load) begin
      nxt_s.shift  = word;
      nxt_s.cnt    = 4'h0;
      nxt_s.active = 1'b1;
      nxt_s.done   = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= '{shift: ALL_ONES, cnt: 4'h0, active: 1'b0, bit_out: 1'b1, done: 1'b0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign tx_bit    = s_ff.bit_out;
  assign word_done = s_ff.done;

endmodule : fct_serializer
`default_nettype wire

/* File: design/fct_top.sv */
// Chosen here: the Avalon-MM register port.
`default_nettype none
module fct_top
  import fct_pkg::*;
#(
  parameter logic [3:0] PORT_PREFIX = 4'h0
)
(
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic [13:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        global_port_status_irq_enable,
  output logic             irq,
  output logic             tx_bit,
  output logic             tx_bit_strobe,
  output logic             tx_idle_live
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SEND_A,
    ST_SEND_B,
    ST_CONT
  } fct_state_t;

  typedef struct packed {
    logic [1:0]  div;
    logic        bit_en;
    logic        strobe;
    logic        ack;
    logic [31:0] rdata;
    logic [1:0]  mode_sel;
    logic        load_trig;
    logic        load_prev;
    logic [5:0]  code_a_reg;
    logic [5:0]  code_b_reg;
    logic        ie;
    logic        latch;
    logic        idle_prev;
    fct_mode_t   act_mode;
    logic [5:0]  act_a;
    logic [5:0]  act_b;
    fct_state_t  state;
    logic [3:0]  reps;
    logic        ser_load;
    logic [15:0] ser_word;
    logic        to_idle;
  } fct_regs_t;

  fct_regs_t r_ff;
  fct_regs_t nxt_r;

  logic [1:0]  rst_sync_ff;
  logic        rst_n;
  logic        ser_done;
  logic        req;
  logic        hit;
  logic [7:0]  idx;
  logic        wr_go;
  logic        rd_go;
  logic        idle_now;
  logic        load_go;
  logic [15:0] ctrl_rd;
  logic [15:0] codes_rd;
  logic [15:0] wr_lo;

  // reset release through two stages
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_ff <= 2'b00;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_ff[1];

  // register decode: index {prefix, offset}, byte address four times it
  assign req      = avs_read | avs_write;
  assign idx      = avs_address[9:2];
  assign hit      = (avs_address[13:10] == PORT_PREFIX) && (avs_address[1:0] == 2'b00);
  assign wr_go    = avs_write & r_ff.ack;
  assign rd_go    = avs_read & ~r_ff.ack;
  assign wr_lo    = avs_writedata[15:0];
  assign idle_now = (r_ff.state == ST_IDLE);
  assign load_go  = r_ff.load_trig & ~r_ff.load_prev;

  assign ctrl_rd  = {13'h0000, r_ff.load_trig, r_ff.mode_sel};
  assign codes_rd = {2'b00, r_ff.code_b_reg, 2'b00, r_ff.code_a_reg};

  always_comb begin
    logic [15:0] mval;
    logic [15:0] rd16;
    mval  = 16'h0000;
    rd16  = 16'h0000;
    nxt_r = r_ff;

    // bit rate enable
    nxt_r.bit_en = 1'b0;
    if (r_ff.div == BIT_DIV_LAST) begin
      nxt_r.div    = 2'h0;
      nxt_r.bit_en = 1'b1;
    end else begin
      nxt_r.div = r_ff.div + 2'h1;
    end
    nxt_r.strobe = r_ff.bit_en;

    // one wait cycle, then the answer
    nxt_r.ack = req & ~r_ff.ack;

    if (rd_go) begin
      if (hit) begin
        unique case (idx)
          IDX_CTRL:  rd16 = ctrl_rd;
          IDX_CODES: rd16 = codes_rd;
          IDX_STATE: rd16 = {15'h0000, idle_now};
          IDX_LATCH: rd16 = {15'h0000, r_ff.latch};
          IDX_IE:    rd16 = {15'h0000, r_ff.ie};
          default:   rd16 = 16'h0000;
        endcase
      end
      nxt_r.rdata = {16'h0000, rd16};
    end

    if (wr_go && hit) begin
      unique case (idx)
        IDX_CTRL: begin
          mval            = fct_merge(ctrl_rd, wr_lo, avs_byteenable[1:0]);
          nxt_r.mode_sel  = mval[CTRL_MODE_LSB +: 2];
          nxt_r.load_trig = mval[CTRL_LOAD_BIT];
        end
        IDX_CODES: begin
          mval             = fct_merge(codes_rd, wr_lo, avs_byteenable[1:0]);
          nxt_r.code_a_reg = mval[CODE_A_LSB +: CODE_W];
          nxt_r.code_b_reg = mval[CODE_B_LSB +: CODE_W];
        end
        IDX_LATCH: begin
          if (avs_byteenable[0] && wr_lo[LATCH_IDLE_BIT]) begin
            nxt_r.latch = 1'b0;
          end
        end
        IDX_IE: begin
          if (avs_byteenable[0]) begin
            nxt_r.ie = wr_lo[IE_IDLE_BIT];
          end
        end
        default: begin
        end
      endcase
    end

    // edge detect is taken on the stored trigger bit
    nxt_r.load_prev = r_ff.load_trig;

    // sequencer
    nxt_r.ser_load = 1'b0;
    if (load_go) begin
      nxt_r.act_mode = fct_mode_t'(r_ff.mode_sel);
      nxt_r.act_a    = r_ff.code_a_reg;
      nxt_r.act_b    = r_ff.code_b_reg;
      nxt_r.ser_load = 1'b1;
      nxt_r.reps     = 4'h1;
      nxt_r.to_idle  = 1'b0;
      unique case (fct_mode_t'(r_ff.mode_sel))
        MODE_IDLE: begin
          // stay busy until a one stands on the pin; ones replace the aborted word at once
          nxt_r.to_idle  = ~idle_now;
          nxt_r.ser_word = ALL_ONES;
        end
        MODE_SINGLE, MODE_DUAL: begin
          nxt_r.state    = ST_SEND_A;
          nxt_r.ser_word = fct_codeword(r_ff.code_a_reg);
        end
        MODE_CONT: begin
          nxt_r.state    = ST_CONT;
          nxt_r.ser_word = fct_codeword(r_ff.code_a_reg);
        end
      endcase
    end else if (ser_done && !r_ff.ser_load && !r_ff.to_idle) begin
      // a done from a word that is being replaced is stale
      unique case (r_ff.state)
        ST_IDLE: begin
        end
        ST_SEND_A: begin
          if (r_ff.reps != REPEAT_COUNT) begin
            nxt_r.reps     = r_ff.reps + 4'h1;
            nxt_r.ser_load = 1'b1;
            nxt_r.ser_word = fct_codeword(r_ff.act_a);
          end else if (r_ff.act_mode == MODE_DUAL) begin
            nxt_r.state    = ST_SEND_B;
            nxt_r.reps     = 4'h1;
            nxt_r.ser_load = 1'b1;
            nxt_r.ser_word = fct_codeword(r_ff.act_b);
          end else begin
            nxt_r.state = ST_IDLE;
          end
        end
        ST_SEND_B: begin
          if (r_ff.reps != REPEAT_COUNT) begin
            nxt_r.reps     = r_ff.reps + 4'h1;
            nxt_r.ser_load = 1'b1;
            nxt_r.ser_word = fct_codeword(r_ff.act_b);
          end else begin
            nxt_r.state = ST_IDLE;
          end
        end
        ST_CONT: begin
          nxt_r.ser_load = 1'b1;
          nxt_r.ser_word = fct_codeword(r_ff.act_a);
        end
      endcase
    end

    // idle only once the replacement ones stand on the pin
    if (r_ff.to_idle && !load_go && !r_ff.ser_load && tx_bit) begin
      nxt_r.state   = ST_IDLE;
      nxt_r.to_idle = 1'b0;
    end

    // idle event: a rise wins over a software clear
    nxt_r.idle_prev = idle_now;
    if (idle_now && !r_ff.idle_prev) begin
      nxt_r.latch = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      r_ff <= '{
        div:        2'h0,
        bit_en:     1'b0,
        strobe:     1'b0,
        ack:        1'b0,
        rdata:      32'h0000_0000,
        mode_sel:   RST_CTRL[1:0],
        load_trig:  RST_CTRL[2],
        load_prev:  RST_CTRL[2],
        code_a_reg: RST_CODE,
        code_b_reg: RST_CODE,
        ie:         RST_IE,
        latch:      RST_LATCH,
        idle_prev:  1'b1,
        act_mode:   MODE_IDLE,
        act_a:      RST_CODE,
        act_b:      RST_CODE,
        state:      ST_IDLE,
        reps:       4'h0,
        ser_load:   1'b0,
        ser_word:   ALL_ONES,
        to_idle:    1'b0
      };
    end else begin
      r_ff <= nxt_r;
    end
  end

  fct_serializer u_ser (
    .clock     (clock),
    .rst_n     (rst_n),
    .bit_en    (r_ff.bit_en),
    .load      (r_ff.ser_load),
    .word      (r_ff.ser_word),
    .tx_bit    (tx_bit),
    .word_done (ser_done)
  );

  assign avs_waitrequest = req & ~r_ff.ack;
  assign avs_readdata    = r_ff.rdata;
  assign irq             = r_ff.latch & r_ff.ie & global_port_status_irq_enable;
  assign tx_bit_strobe   = r_ff.strobe;
  assign tx_idle_live    = idle_now;

endmodule : fct_top
`default_nettype wire

/* File: inc/fct_pkg.sv */
`default_nettype none
package fct_pkg;
  localparam int          CLK_HZ       = 20_000_000;
  localparam int          BIT_HZ       = 5_000_000;
  localparam int          BIT_DIV      = CLK_HZ / BIT_HZ;
  localparam logic [1:0]  BIT_DIV_LAST = 2'(BIT_DIV - 1);

  localparam logic [7:0]  IDX_CTRL  = 8'hc0;
  localparam logic [7:0]  IDX_CODES = 8'hc2;
  localparam logic [7:0]  IDX_STATE = 8'hc4;
  localparam logic [7:0]  IDX_LATCH = 8'hc6;
  localparam logic [7:0]  IDX_IE    = 8'hc8;

  localparam int          CTRL_MODE_LSB  = 0;
  localparam int          CTRL_LOAD_BIT  = 2;
  localparam int          CODE_A_LSB     = 0;
  localparam int          CODE_B_LSB     = 8;
  localparam int          CODE_W         = 6;
  localparam int          STATE_IDLE_BIT = 0;
  localparam int          LATCH_IDLE_BIT = 0;
  localparam int          IE_IDLE_BIT    = 0;

  localparam logic [2:0]  RST_CTRL  = 3'h0;
  localparam logic [5:0]  RST_CODE  = 6'h00;
  localparam logic        RST_LATCH = 1'b1;
  localparam logic        RST_IE    = 1'b0;

  localparam logic [3:0]  REPEAT_COUNT = 4'ha;
  localparam logic [3:0]  WORD_LAST    = 4'hf;
  localparam logic [15:0] ALL_ONES     = 16'hffff;

  typedef enum logic [1:0] {
    MODE_IDLE   = 2'h0,
    MODE_SINGLE = 2'h1,
    MODE_DUAL   = 2'h2,
    MODE_CONT   = 2'h3
  } fct_mode_t;

  // lsb goes out first: 0, c1..c6, 0, eight ones
  function automatic logic [15:0] fct_codeword(input logic [5:0] code);
    return {8'hff, 1'b0, code, 1'b0};
  endfunction : fct_codeword

  function automatic logic [15:0] fct_merge(input logic [15:0] old,
                                            input logic [15:0] data,
                                            input logic [1:0]  be);
    return {be[1] ? data[15:8] : old[15:8], be[0] ? data[7:0] : old[7:0]};
  endfunction : fct_merge
endpackage : fct_pkg
`default_nettype wire

/* File: testbench/fct_link_model.sv */
`default_nettype none
module fct_link_model (
  input wire logic clock,
  input wire logic tx_bit,
  input wire logic tx_bit_strobe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] win_ff = 16'hffff;
  logic [5:0]  codes[$];
  // first bit sent ends up at the bottom of the window
  always @(posedge clock) begin
    if (tx_bit_strobe) begin
      win_ff <= {tx_bit, win_ff[15:1]};
      if ({tx_bit, win_ff[15:9]} == 8'hff && !win_ff[8] && !win_ff[1]) begin
        codes.push_back(win_ff[7:2]);
      end
    end
  end
endmodule : fct_link_model
`default_nettype wire

/* File: testbench/fct_top_chk.sv */
`default_nettype none
module fct_top_chk (
  input wire logic        clock,
  input wire logic        reset_n,
  input wire logic [13:0] avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        global_port_status_irq_enable,
  input wire logic        irq,
  input wire logic        tx_bit,
  input wire logic        tx_bit_strobe,
  input wire logic        tx_idle_live
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  sequence req_start;
    (avs_read || avs_write) && !$past(avs_read || avs_write);
  endsequence
  sequence one_wait;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  a_bus_one_wait: assert property (req_start |-> one_wait)
    else $error("bus answer not after one wait state");
  a_bus_idle_free: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest without request");
  a_read_upper_zero: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:16] == 16'h0)
    else $error("upper read half not zero");
  a_irq_port_gate: assert property (!global_port_status_irq_enable |-> !irq)
    else $error("irq without port enable");
  a_idle_sends_ones: assert property (tx_idle_live |-> tx_bit)
    else $error("zero bit while idle");
  a_strobe_period: assert property (tx_bit_strobe |=> !tx_bit_strobe [*3] ##1 tx_bit_strobe)
    else $error("bit strobe period wrong");
  a_bit_on_strobe: assert property ($changed(tx_bit) && !tx_idle_live |-> tx_bit_strobe)
    else $error("bit changed off strobe");
  a_word_starts_zero: assert property ($fell(tx_idle_live) |-> ##[1:8] (tx_bit_strobe && !tx_bit))
    else $error("codeword does not open with zero");
endmodule : fct_top_chk
`default_nettype wire

/* File: testbench/fct_top_test.sv */
`default_nettype none
module fct_top_test import fct_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  logic [13:0] avs_address = 14'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'h3;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest, irq, tx_bit, tx_bit_strobe, tx_idle_live;
  logic        glob_en = 1'b0;
  logic [15:0] rdata;
  int          n_errors = 0;
  int          samples_checked = 0;
  always #25 clock = ~clock;
  fct_top fct_top_i (.clock(clock), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .global_port_status_irq_enable(glob_en), .irq(irq), .tx_bit(tx_bit),
    .tx_bit_strobe(tx_bit_strobe), .tx_idle_live(tx_idle_live));
  fct_link_model fct_link_model_i (.clock(clock), .tx_bit(tx_bit),
    .tx_bit_strobe(tx_bit_strobe));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    $display("compared %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [15:0] d);
    int n;
    @(posedge clock);
    avs_address <= {4'h0, idx, 2'h0};
    avs_writedata <= {16'h0, d};
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    // values as the accepting edge sees them, before its updates land
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rdata = avs_readdata[15:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 20) begin
      n_errors++;
      conclude();
    end
  endtask : bus
  task automatic rd(input logic [7:0] idx, input logic [15:0] exp);
    bus(1'b0, idx, 16'h0);
    check(rdata, exp);
  endtask : rd
  task automatic load(input logic [1:0] m);
    bus(1'b1, IDX_CTRL, {14'h0, m});
    bus(1'b1, IDX_CTRL, {13'h0, 1'b1, m});
  endtask : load
  task automatic wait_idle(input logic lvl, input int lim);
    int n;
    n = 0;
    while (tx_idle_live !== lvl && n < lim) begin
      @(negedge clock);
      n++;
    end
    if (n >= lim) begin
      n_errors++;
      conclude();
    end
  endtask : wait_idle
  task automatic codes_are(input int cnt, input logic [5:0] a, input logic [5:0] b);
    check(16'(fct_link_model_i.codes.size()), 16'(cnt));
    foreach (fct_link_model_i.codes[i]) begin
      check(16'(fct_link_model_i.codes[i]), 16'(i < 10 ? a : b));
    end
    fct_link_model_i.codes.delete();
  endtask : codes_are
  initial begin
    repeat (6) @(posedge clock);
    reset_n <= 1'b1;
    repeat (3) @(posedge clock);
    rd(IDX_LATCH, 16'h1);
    rd(IDX_STATE, 16'h1);
    rd(IDX_IE, 16'h0);
    rd(8'hca, 16'h0);
    bus(1'b1, IDX_STATE, 16'h0);
    rd(IDX_STATE, 16'h1);
    bus(1'b1, IDX_CODES, 16'hea15);
    rd(IDX_CODES, 16'h2a15);
    avs_byteenable <= 4'h2;
    bus(1'b1, IDX_CODES, 16'h0100);
    avs_byteenable <= 4'h3;
    rd(IDX_CODES, 16'h0115);
    bus(1'b1, IDX_CODES, 16'hea15);
    bus(1'b1, IDX_IE, 16'h1);
    glob_en <= 1'b1;
    @(negedge clock);
    check(16'(irq), 16'h1);
    bus(1'b1, IDX_LATCH, 16'h1);
    @(negedge clock);
    check(16'(irq), 16'h0);
    $display("registers and interrupt done");
    load(2'h1);
    wait_idle(1'b0, 10);
    wait_idle(1'b1, 800);
    codes_are(10, 6'h15, 6'h15);
    rd(IDX_LATCH, 16'h1);
    check(16'(irq), 16'h1);
    glob_en <= 1'b0;
    @(negedge clock);
    check(16'(irq), 16'h0);
    @(posedge clock);
    glob_en <= 1'b1;
    bus(1'b1, IDX_LATCH, 16'h1);
    load(2'h2);
    rd(IDX_CTRL, 16'h6);
    wait_idle(1'b0, 10);
    wait_idle(1'b1, 1500);
    codes_are(20, 6'h15, 6'h2a);
    $display("single and dual done");
    load(2'h3);
    repeat (1300) @(posedge clock);
    check(16'(tx_idle_live), 16'h0);
    check(16'(fct_link_model_i.codes.size() >= 19), 16'h1);
    bus(1'b1, IDX_CODES, 16'h000b);
    load(2'h1);
    repeat (8) @(posedge clock);
    fct_link_model_i.codes.delete();
    wait_idle(1'b1, 800);
    codes_are(10, 6'h0b, 6'h0b);
    load(2'h3);
    wait_idle(1'b0, 10);
    repeat (100) @(posedge clock);
    load(2'h0);
    wait_idle(1'b1, 20);
    // let the tail of the aborted word drain before counting
    repeat (80) @(posedge clock);
    fct_link_model_i.codes.delete();
    repeat (200) @(posedge clock);
    check(16'(fct_link_model_i.codes.size()), 16'h0);
    $display("continuous and abort done");
    conclude();
  end
endmodule : fct_top_test
bind fct_top fct_top_chk fct_top_chk_i (.clock(clock), .reset_n(reset_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .global_port_status_irq_enable(global_port_status_irq_enable), .irq(irq),
  .tx_bit(tx_bit), .tx_bit_strobe(tx_bit_strobe), .tx_idle_live(tx_idle_live));
`default_nettype wire
